// ---- csia_pkg.sv ----
// Purpose: Shared constants and types for the core register bank.
// Assumes: Registers sit one per 32-bit word; byte address = index * 4.
// Notes:   Indices below are register indices, not byte addresses.
package csia_pkg;

  localparam int         CSIA_PTR_W  = 11;
  localparam int         CSIA_DMEM_N = 2048;
  localparam int         CSIA_ADR_W  = 8;

  // Register indices.
  localparam logic [5:0] OFS_INDIRECT_PORT0_PLAIN    = 6'h00;
  localparam logic [5:0] OFS_INDIRECT_PORT0_POST_INC = 6'h01;
  localparam logic [5:0] OFS_INDIRECT_PORT0_POST_DEC = 6'h02;
  localparam logic [5:0] OFS_INDIRECT_PORT0_PRE_INC  = 6'h03;
  localparam logic [5:0] OFS_INDIRECT_PORT0_W_OFFSET = 6'h04;
  localparam logic [5:0] OFS_INDIRECT_PORT1_PLAIN    = 6'h05;
  localparam logic [5:0] OFS_INDIRECT_PORT1_POST_INC = 6'h06;
  localparam logic [5:0] OFS_INDIRECT_PORT1_POST_DEC = 6'h07;
  localparam logic [5:0] OFS_INDIRECT_PORT1_PRE_INC  = 6'h08;
  localparam logic [5:0] OFS_INDIRECT_PORT1_W_OFFSET = 6'h09;
  localparam logic [5:0] OFS_INDIRECT_PORT2_PLAIN    = 6'h0a;
  localparam logic [5:0] OFS_INDIRECT_PORT2_POST_INC = 6'h0b;
  localparam logic [5:0] OFS_INDIRECT_PORT2_POST_DEC = 6'h0c;
  localparam logic [5:0] OFS_INDIRECT_PORT2_PRE_INC  = 6'h0d;
  localparam logic [5:0] OFS_INDIRECT_PORT2_W_OFFSET = 6'h0e;
  localparam logic [5:0] OFS_POINTER0_HIGH           = 6'h0f;
  localparam logic [5:0] OFS_POINTER0_LOW            = 6'h10;
  localparam logic [5:0] OFS_POINTER1_HIGH           = 6'h11;
  localparam logic [5:0] OFS_POINTER1_LOW            = 6'h12;
  localparam logic [5:0] OFS_POINTER2_HIGH           = 6'h13;
  localparam logic [5:0] OFS_POINTER2_LOW            = 6'h14;
  localparam logic [5:0] OFS_STACK_TOP_UPPER         = 6'h15;
  localparam logic [5:0] OFS_STACK_TOP_HIGH          = 6'h16;
  localparam logic [5:0] OFS_STACK_TOP_LOW           = 6'h17;
  localparam logic [5:0] OFS_STACK_CONTROL           = 6'h18;
  localparam logic [5:0] OFS_PC_LATCH_UPPER          = 6'h19;
  localparam logic [5:0] OFS_PC_LATCH_HIGH           = 6'h1a;
  localparam logic [5:0] OFS_PC_LATCH_LOW            = 6'h1b;
  localparam logic [5:0] OFS_TABLE_POINTER_UPPER     = 6'h1c;
  localparam logic [5:0] OFS_TABLE_POINTER_HIGH      = 6'h1d;
  localparam logic [5:0] OFS_TABLE_POINTER_LOW       = 6'h1e;
  localparam logic [5:0] OFS_TABLE_LATCH_HIGH        = 6'h1f;
  localparam logic [5:0] OFS_TABLE_LATCH_LOW         = 6'h20;
  localparam logic [5:0] OFS_PRODUCT_HIGH            = 6'h21;
  localparam logic [5:0] OFS_PRODUCT_LOW             = 6'h22;
  localparam logic [5:0] OFS_INTERRUPT_ENABLE_0      = 6'h23;
  localparam logic [5:0] OFS_INTERRUPT_ENABLE_1      = 6'h24;
  localparam logic [5:0] OFS_INTERRUPT_ENABLE_2      = 6'h25;
  localparam logic [5:0] OFS_INTERRUPT_FLAG_0        = 6'h26;
  localparam logic [5:0] OFS_INTERRUPT_FLAG_1        = 6'h27;
  localparam logic [5:0] OFS_INTERRUPT_FLAG_2        = 6'h28;
  localparam logic [5:0] OFS_WORKING_ACCUMULATOR     = 6'h29;
  localparam logic [5:0] OFS_BANK_SELECT             = 6'h2a;
  localparam logic [5:0] OFS_ALU_STATUS              = 6'h2b;

  // Values after reset.
  localparam logic [7:0]  RST_DATA          = 8'h00;
  localparam logic [7:0]  RST_STACK_CONTROL = 8'h00;
  localparam logic [13:0] RST_PC_LATCH      = 14'h0000;
  localparam logic [23:0] RST_INTERRUPT     = 24'h000000;

  // Implemented bits of the interrupt bytes, byte 2 in the top lane.
  localparam logic [23:0] MASK_ENABLE = 24'h7fffff;
  localparam logic [23:0] MASK_FLAG   = 24'hffff7f;
  // Stack status bits that software may only clear.
  localparam logic [7:0]  MASK_STACK_CLEAR_ONLY = 8'hc0;

  typedef enum logic [2:0] {
    CSIA_PLAIN    = 3'b000,
    CSIA_POST_INC = 3'b001,
    CSIA_POST_DEC = 3'b010,
    CSIA_PRE_INC  = 3'b011,
    CSIA_W_OFFSET = 3'b100
  } csia_mode_type;

endpackage

// ---- csia_ptr_unit.sv ----
// Purpose: One indirect data-memory pointer with its access arithmetic.
// Assumes: step is a one-cycle pulse at the completion of an access.
// Notes:   addr is combinational; it is the address the access reaches.
`timescale 1ns/1ps
module csia_ptr_unit #(
  parameter int PTR_W = csia_pkg::CSIA_PTR_W
) (
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  input  wire logic                   low_we,
  input  wire logic                   high_we,
  input  wire logic [7:0]             wdata,
  input  wire logic                   step,
  input  wire csia_pkg::csia_mode_type mode,
  input  wire logic [7:0]             offset,
  output logic      [PTR_W-1:0]       ptr,
  output logic      [PTR_W-1:0]       addr
);
  import csia_pkg::*;

  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;
  logic [PTR_W-1:0] ptr_off;

  // All sums drop the carry, so the address wraps in the pointer range.
  assign ptr_inc = ptr + PTR_W'(1);               // see (RL12)
  assign ptr_dec = ptr - PTR_W'(1);               // see (RL12)
  assign ptr_off = ptr + PTR_W'(offset);          // see (RL5) (RL12)

  assign addr = (mode == CSIA_PRE_INC)  ? ptr_inc :  // see (RL4)
                (mode == CSIA_W_OFFSET) ? ptr_off :  // see (RL5)
                ptr;                                 // see (RL1) (RL2) (RL3)

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ptr <= PTR_W'(RST_DATA);
    end else if (step) begin
      case (mode)
        CSIA_POST_INC: ptr <= ptr_inc;            // see (RL2)
        CSIA_PRE_INC:  ptr <= ptr_inc;            // see (RL4)
        CSIA_POST_DEC: ptr <= ptr_dec;            // see (RL3)
        default:       ptr <= ptr;                // see (RL1) (RL5)
      endcase
    end else begin
      if (low_we) begin
        ptr[7:0] <= wdata;                        // see (RL6)
      end
      if (high_we) begin
        ptr[PTR_W-1:8] <= wdata[PTR_W-9:0];       // see (RL6)
      end
    end
  end

endmodule

// ---- csia_sfr_bank.sv ----
// Purpose: Core special-function register bank on a Wishbone slave.
// Assumes: Classic Wishbone, one 8-bit register per aligned 32-bit word.
// Notes:   Side effects of an access land on the edge that completes it.
// Functional notes
// (RL1) Plain port reaches memory, pointer unchanged
// (RL2) Post-increment port uses pointer, then adds one
// (RL3) Post-decrement port uses pointer, then subtracts one
// (RL4) Pre-increment port adds one, then reaches memory
// (RL5) Offset port reaches pointer plus working accumulator
// (RL6) Pointers are 11 bits, low and high registers
// (RL7) Stack top is 14 bits, upper register unused
// (RL8) Program counter latch is 14 bits, resets zero
// (RL9) Table pointer is 14 bits, low and high
// (RL10) Two-byte table latch, readable and writable
// (RL11) Multiply result lands in product high and low
// (RL12) Pointer arithmetic wraps in the 11-bit range
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
module csia_sfr_bank #(
  parameter int DMEM_N = csia_pkg::CSIA_DMEM_N
) (
  input  wire logic                          ref_clk,
  input  wire logic                          resetn,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [csia_pkg::CSIA_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          mul_load,
  input  wire logic [7:0]                    mul_operand,
  input  wire logic                          table_load,
  input  wire logic [15:0]                   table_word,
  input  wire logic                          stack_load,
  input  wire logic [13:0]                   stack_value,
  input  wire logic                          stack_full_set,
  input  wire logic                          stack_under_set,
  input  wire logic                          status_load,
  input  wire logic [4:0]                    status_value,
  input  wire logic [23:0]                   int_flag_set,
  output logic      [13:0]                   program_counter_latch,
  output logic      [13:0]                   program_table_pointer,
  output logic      [13:0]                   stack_top_address,
  output logic      [7:0]                    stack_control,
  output logic      [15:0]                   table_latch,
  output logic      [15:0]                   product_word,
  output logic      [7:0]                    working_accumulator,
  output logic      [2:0]                    bank_select,
  output logic      [4:0]                    alu_status,
  output logic      [23:0]                   int_enable,
  output logic      [23:0]                   int_flag
);
  import csia_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  ////////////////////////////////////////////////////////////////////////////

  logic [5:0]  idx;
  logic [7:0]  wdat;
  logic        req;
  logic        start;
  logic        take;
  logic        wr_hit;
  logic        is_ind;
  logic [1:0]  grp;
  logic [5:0]  ind_off;
  csia_mode_type ind_mode;

  assign idx   = wb_adr_i[CSIA_ADR_W-1:2];
  assign wdat  = wb_dat_i[7:0];
  assign req   = wb_cyc_i & wb_stb_i;
  // A request is sampled for read data when it arrives and its side
  // effects happen on the edge where the master sees the acknowledge.
  assign start = req & ~wb_ack_o;
  assign take  = req & wb_ack_o;
  // Registers are one byte wide, so only lane zero carries write data.
  assign wr_hit = take & wb_we_i & wb_sel_i[0];

  assign is_ind  = (idx < OFS_POINTER0_HIGH);
  assign grp     = (idx >= OFS_INDIRECT_PORT2_PLAIN) ? 2'd2 :
                   (idx >= OFS_INDIRECT_PORT1_PLAIN) ? 2'd1 : 2'd0;
  assign ind_off = (grp == 2'd2) ? idx - OFS_INDIRECT_PORT2_PLAIN :
                   (grp == 2'd1) ? idx - OFS_INDIRECT_PORT1_PLAIN :
                   idx - OFS_INDIRECT_PORT0_PLAIN;
  assign ind_mode = csia_mode_type'(ind_off[2:0]);

  wire we_p0h    = wr_hit && (idx == OFS_POINTER0_HIGH);
  wire we_p0l    = wr_hit && (idx == OFS_POINTER0_LOW);
  wire we_p1h    = wr_hit && (idx == OFS_POINTER1_HIGH);
  wire we_p1l    = wr_hit && (idx == OFS_POINTER1_LOW);
  wire we_p2h    = wr_hit && (idx == OFS_POINTER2_HIGH);
  wire we_p2l    = wr_hit && (idx == OFS_POINTER2_LOW);
  wire we_tos_h  = wr_hit && (idx == OFS_STACK_TOP_HIGH);
  wire we_tos_l  = wr_hit && (idx == OFS_STACK_TOP_LOW);
  wire we_stk    = wr_hit && (idx == OFS_STACK_CONTROL);
  wire we_pc_h   = wr_hit && (idx == OFS_PC_LATCH_HIGH);
  wire we_pc_l   = wr_hit && (idx == OFS_PC_LATCH_LOW);
  wire we_tbp_h  = wr_hit && (idx == OFS_TABLE_POINTER_HIGH);
  wire we_tbp_l  = wr_hit && (idx == OFS_TABLE_POINTER_LOW);
  wire we_tbl_h  = wr_hit && (idx == OFS_TABLE_LATCH_HIGH);
  wire we_tbl_l  = wr_hit && (idx == OFS_TABLE_LATCH_LOW);
  wire we_prod_h = wr_hit && (idx == OFS_PRODUCT_HIGH);
  wire we_prod_l = wr_hit && (idx == OFS_PRODUCT_LOW);
  wire we_en0    = wr_hit && (idx == OFS_INTERRUPT_ENABLE_0);
  wire we_en1    = wr_hit && (idx == OFS_INTERRUPT_ENABLE_1);
  wire we_en2    = wr_hit && (idx == OFS_INTERRUPT_ENABLE_2);
  wire we_fl0    = wr_hit && (idx == OFS_INTERRUPT_FLAG_0);
  wire we_fl1    = wr_hit && (idx == OFS_INTERRUPT_FLAG_1);
  wire we_fl2    = wr_hit && (idx == OFS_INTERRUPT_FLAG_2);
  wire we_wacc   = wr_hit && (idx == OFS_WORKING_ACCUMULATOR);
  wire we_bank   = wr_hit && (idx == OFS_BANK_SELECT);
  wire we_alu    = wr_hit && (idx == OFS_ALU_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Indirect pointers and data memory
  ////////////////////////////////////////////////////////////////////////////

  logic [CSIA_PTR_W-1:0] ptr_a;
  logic [CSIA_PTR_W-1:0] ptr_b;
  logic [CSIA_PTR_W-1:0] ptr_c;
  logic [CSIA_PTR_W-1:0] addr_a;
  logic [CSIA_PTR_W-1:0] addr_b;
  logic [CSIA_PTR_W-1:0] addr_c;
  logic [CSIA_PTR_W-1:0] ind_addr;
  logic                  step_a;
  logic                  step_b;
  logic                  step_c;

  // Reads move the pointer just as writes do.
  assign step_a = take & is_ind & (grp == 2'd0);
  assign step_b = take & is_ind & (grp == 2'd1);
  assign step_c = take & is_ind & (grp == 2'd2);

  csia_ptr_unit #(.PTR_W(CSIA_PTR_W)) indirect_pointer_a (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .low_we  (we_p0l),
    .high_we (we_p0h),
    .wdata   (wdat),
    .step    (step_a),
    .mode    (ind_mode),
    .offset  (working_accumulator),
    .ptr     (ptr_a),
    .addr    (addr_a)
  );

  csia_ptr_unit #(.PTR_W(CSIA_PTR_W)) indirect_pointer_b (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .low_we  (we_p1l),
    .high_we (we_p1h),
    .wdata   (wdat),
    .step    (step_b),
    .mode    (ind_mode),
    .offset  (working_accumulator),
    .ptr     (ptr_b),
    .addr    (addr_b)
  );

  csia_ptr_unit #(.PTR_W(CSIA_PTR_W)) indirect_pointer_c (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .low_we  (we_p2l),
    .high_we (we_p2h),
    .wdata   (wdat),
    .step    (step_c),
    .mode    (ind_mode),
    .offset  (working_accumulator),
    .ptr     (ptr_c),
    .addr    (addr_c)
  );

  assign ind_addr = (grp == 2'd2) ? addr_c :
                    (grp == 2'd1) ? addr_b : addr_a;

  // Data memory has no reset; software must fill it before reading.
  logic [7:0] dmem [DMEM_N];
  logic [7:0] dmem_rd;

  assign dmem_rd = dmem[ind_addr];                // see (RL1)

  always_ff @(posedge ref_clk) begin
    if (wr_hit && is_ind) dmem[ind_addr] <= wdat; // see (RL2) (RL3) (RL4)
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read selection
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] rd_byte;

  // Unused and reserved bits, and unmapped words, read as zero.
  assign rd_byte =
    is_ind                          ? dmem_rd :
    (idx == OFS_POINTER0_HIGH)      ? {5'h00, ptr_a[10:8]} :
    (idx == OFS_POINTER0_LOW)       ? ptr_a[7:0] :
    (idx == OFS_POINTER1_HIGH)      ? {5'h00, ptr_b[10:8]} :
    (idx == OFS_POINTER1_LOW)       ? ptr_b[7:0] :
    (idx == OFS_POINTER2_HIGH)      ? {5'h00, ptr_c[10:8]} :
    (idx == OFS_POINTER2_LOW)       ? ptr_c[7:0] :
    (idx == OFS_STACK_TOP_HIGH)     ? {2'h0, stack_top_address[13:8]} :
    (idx == OFS_STACK_TOP_LOW)      ? stack_top_address[7:0] :
    (idx == OFS_STACK_CONTROL)      ? stack_control :
    (idx == OFS_PC_LATCH_HIGH)      ? {2'h0, program_counter_latch[13:8]} :
    (idx == OFS_PC_LATCH_LOW)       ? program_counter_latch[7:0] :
    (idx == OFS_TABLE_POINTER_HIGH) ? {2'h0, program_table_pointer[13:8]} :
    (idx == OFS_TABLE_POINTER_LOW)  ? program_table_pointer[7:0] :
    (idx == OFS_TABLE_LATCH_HIGH)   ? table_latch[15:8] :
    (idx == OFS_TABLE_LATCH_LOW)    ? table_latch[7:0] :
    (idx == OFS_PRODUCT_HIGH)       ? product_word[15:8] :
    (idx == OFS_PRODUCT_LOW)        ? product_word[7:0] :
    (idx == OFS_INTERRUPT_ENABLE_0) ? int_enable[7:0] :
    (idx == OFS_INTERRUPT_ENABLE_1) ? int_enable[15:8] :
    (idx == OFS_INTERRUPT_ENABLE_2) ? int_enable[23:16] :
    (idx == OFS_INTERRUPT_FLAG_0)   ? int_flag[7:0] :
    (idx == OFS_INTERRUPT_FLAG_1)   ? int_flag[15:8] :
    (idx == OFS_INTERRUPT_FLAG_2)   ? int_flag[23:16] :
    (idx == OFS_WORKING_ACCUMULATOR) ? working_accumulator :
    (idx == OFS_BANK_SELECT)        ? {5'h00, bank_select} :
    (idx == OFS_ALU_STATUS)         ? {3'h0, alu_status} :
    8'h00;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= start;
      if (start) wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter latch, stack top and table pointer
  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      program_counter_latch <= RST_PC_LATCH;      // see (RL8)
    end else begin
      if (we_pc_h) program_counter_latch[13:8] <= wdat[5:0]; // see (RL8)
      if (we_pc_l) program_counter_latch[7:0] <= wdat;       // see (RL8)
    end
  end

  // A push or pop from the core takes priority over a software write.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stack_top_address <= {RST_DATA[5:0], RST_DATA};
    end else if (stack_load) begin
      stack_top_address <= stack_value;           // see (RL7)
    end else begin
      if (we_tos_h) stack_top_address[13:8] <= wdat[5:0]; // see (RL7)
      if (we_tos_l) stack_top_address[7:0] <= wdat;       // see (RL7)
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      program_table_pointer <= {RST_DATA[5:0], RST_DATA};
    end else begin
      if (we_tbp_h) program_table_pointer[13:8] <= wdat[5:0]; // see (RL9)
      if (we_tbp_l) program_table_pointer[7:0] <= wdat;       // see (RL9)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack control: the two top bits are set by the core, cleared by writes
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] stk_sw;
  logic [7:0] next_stack_control;

  assign stk_sw = we_stk ?
    ((stack_control & wdat & MASK_STACK_CLEAR_ONLY) |
     (wdat & ~MASK_STACK_CLEAR_ONLY)) : stack_control;
  // A set arriving with a clearing write wins, so no event is lost.
  assign next_stack_control = stk_sw |
    {stack_full_set, stack_under_set, 6'h00};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) stack_control <= RST_STACK_CONTROL;
    else stack_control <= next_stack_control;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table latch and product
  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      table_latch <= {RST_DATA, RST_DATA};
    end else if (table_load) begin
      table_latch <= table_word;                  // see (RL10)
    end else begin
      if (we_tbl_h) table_latch[15:8] <= wdat; // see (RL10)
      if (we_tbl_l) table_latch[7:0] <= wdat;  // see (RL10)
    end
  end

  // The multiplier takes the working accumulator as its first operand.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      product_word <= {RST_DATA, RST_DATA};
    end else if (mul_load) begin // see (RL11)
      product_word <= 16'(working_accumulator) * 16'(mul_operand);
    end else begin
      if (we_prod_h) product_word[15:8] <= wdat; // see (RL11)
      if (we_prod_l) product_word[7:0] <= wdat;  // see (RL11)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enable and flag bytes
  ////////////////////////////////////////////////////////////////////////////

  logic [23:0] en_we;
  logic [23:0] fl_we;
  logic [23:0] wdat3;
  logic [23:0] next_int_enable;
  logic [23:0] next_int_flag;

  assign wdat3 = {3{wdat}};
  assign en_we = {{8{we_en2}}, {8{we_en1}}, {8{we_en0}}};
  assign fl_we = {{8{we_fl2}}, {8{we_fl1}}, {8{we_fl0}}};
  assign next_int_enable =
    ((int_enable & ~en_we) | (wdat3 & en_we)) & MASK_ENABLE;
  // Hardware sets override a clear written in the same cycle.
  assign next_int_flag =
    ((int_flag & ~fl_we) | (wdat3 & fl_we) | int_flag_set) & MASK_FLAG;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      int_enable <= RST_INTERRUPT;
      int_flag   <= RST_INTERRUPT;
    end else begin
      int_enable <= next_int_enable;
      int_flag   <= next_int_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working accumulator, bank select and ALU status
  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      working_accumulator <= RST_DATA;
      bank_select         <= RST_DATA[2:0];
      alu_status          <= RST_DATA[4:0];
    end else begin
      if (we_wacc) working_accumulator <= wdat;
      if (we_bank) bank_select <= wdat[2:0];
      if (status_load) begin
        alu_status <= status_value;
      end else if (we_alu) begin
        alu_status <= wdat[4:0];
      end
    end
  end

endmodule

// ---- csia_asserts.sv ----
// Purpose: Bus timing and core-load checks on the register bank.
// Assumes: Classic Wishbone with a one-cycle registered answer.
// Notes:   Strobes stay low in reset, so $past never sees a stale load.
`timescale 1ns/1ps
module csia_asserts
  import csia_pkg::*;
(
  input wire logic                          ref_clk,
  input wire logic                          resetn,
  input wire logic                          wb_cyc_i,
  input wire logic                          wb_stb_i,
  input wire logic                          wb_we_i,
  input wire logic [csia_pkg::CSIA_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]                    wb_sel_i,
  input wire logic [31:0]                   wb_dat_i,
  input wire logic [31:0]                   wb_dat_o,
  input wire logic                          wb_ack_o,
  input wire logic                          mul_load,
  input wire logic [7:0]                    mul_operand,
  input wire logic                          table_load,
  input wire logic [15:0]                   table_word,
  input wire logic                          stack_load,
  input wire logic [13:0]                   stack_value,
  input wire logic [13:0]                   stack_top_address,
  input wire logic [15:0]                   table_latch,
  input wire logic [15:0]                   product_word,
  input wire logic [7:0]                    working_accumulator
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire req = wb_cyc_i & wb_stb_i;
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_timing_a: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_idle_a: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  product_load_a: assert property (mul_load |=> product_word ==
    16'($past(working_accumulator)) * 16'($past(mul_operand)))
    else $error("bad product");
  table_load_a: assert property (table_load |=>
    table_latch == $past(table_word)) else $error("bad table latch");
  stack_load_a: assert property (stack_load |=>
    stack_top_address == $past(stack_value)) else $error("bad stack top");
  accum_write_a: assert property (req && wb_ack_o && wb_we_i &&
    wb_sel_i[0] && wb_adr_i[7:2] == OFS_WORKING_ACCUMULATOR |=>
    working_accumulator == 8'($past(wb_dat_i))) else $error("bad w write");
endmodule
////////////////////////////////////////////////////////////////////////
bind csia_sfr_bank csia_asserts u_chk (.ref_clk, .resetn, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .mul_load, .mul_operand, .table_load, .table_word,
  .stack_load, .stack_value, .stack_top_address, .table_latch,
  .product_word, .working_accumulator);

// ---- csia_core_model.sv ----
// Purpose: Datapath side that loads product, table latch and stack top.
// Assumes: Each load is a one-cycle strobe taken on a rising edge.
// Notes:   Kind 0 multiply, 1 table word, 2 stack value.
`timescale 1ns/1ps
module csia_core_model (
  input  wire logic ref_clk,
  output logic      mul_load,
  output logic [7:0]  mul_operand,
  output logic      table_load,
  output logic [15:0] table_word,
  output logic      stack_load,
  output logic [13:0] stack_value
);
  initial {mul_load, mul_operand, table_load, table_word} = '0;
  initial {stack_load, stack_value} = '0;
  task pulse(input logic [1:0] k, input logic [15:0] v);
    @(posedge ref_clk);
    mul_operand <= v[7:0];
    table_word  <= v;
    stack_value <= v[13:0];
    mul_load    <= (k == 2'd0);
    table_load  <= (k == 2'd1);
    stack_load  <= (k == 2'd2);
    @(posedge ref_clk);
    {mul_load, table_load, stack_load} <= 3'b000;
  endtask
endmodule

// ---- testbench.sv ----
// Purpose: Self-checking bench for the core register bank.
// Assumes: Data memory holds no reset value, so it is written first.
// Notes:   Rows are register index, write byte, expected read byte.
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = '0;
  logic [3:0]  wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic wb_ack_o, mul_load, table_load, stack_load;
  logic [7:0]  mul_operand;
  logic [15:0] table_word;
  logic [13:0] stack_value;
  int mismatches = 0, checks_done = 0, cycles = 0;
  logic [21:0] rows [13] = '{{6'h0f, 16'hff07}, {6'h1a, 16'hff3f},
    {6'h1d, 16'hff3f}, {6'h16, 16'hff3f}, {6'h15, 16'hff00},
    {6'h1f, 16'ha5a5}, {6'h21, 16'h3c3c}, {6'h3f, 16'h5a00},
    {6'h18, 16'hff3f}, {6'h25, 16'hff7f}, {6'h26, 16'hff7f},
    {6'h2a, 16'hff07}, {6'h2b, 16'hff1f}};
  always #5 ref_clk = ~ref_clk;
  csia_core_model core (.ref_clk, .mul_load, .mul_operand, .table_load,
    .table_word, .stack_load, .stack_value);
  csia_sfr_bank DUT (.ref_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mul_load,
    .mul_operand, .table_load, .table_word, .stack_load, .stack_value,
    .stack_full_set(1'b0), .stack_under_set(1'b0), .status_load(1'b0),
    .status_value(5'h00), .int_flag_set(24'h000000),
    .program_counter_latch(), .program_table_pointer(),
    .stack_top_address(), .stack_control(), .table_latch(),
    .product_word(), .working_accumulator(), .bank_select(),
    .alu_status(), .int_enable(), .int_flag());
  ////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // The master waits on ack; only the cycle ceiling ends a hang.
  task wb(input logic w, input logic [5:0] i, input logic [7:0] d,
          output logic [7:0] q);
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'h1};
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {24'h0, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, i, d, q);
  endtask
  task rd(input logic [5:0] i, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, i, 8'h00, q);
    chk(q, e);
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      end_sim;
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(6'h1b, 8'h00);
    foreach (rows[n]) begin
      wr(rows[n][21:16], rows[n][15:8]);
      rd(rows[n][21:16], rows[n][7:0]);
    end
    wr(6'h0f, 8'h07);
    wr(6'h10, 8'hff);
    wr(6'h01, 8'h11);
    rd(6'h10, 8'h00);
    rd(6'h0f, 8'h00);
    wr(6'h00, 8'h22);
    rd(6'h00, 8'h22);
    rd(6'h10, 8'h00);
    wr(6'h03, 8'h33);
    rd(6'h10, 8'h01);
    rd(6'h02, 8'h33);
    rd(6'h10, 8'h00);
    wr(6'h29, 8'h01);
    rd(6'h04, 8'h33);
    wr(6'h11, 8'h07);
    wr(6'h12, 8'hff);
    rd(6'h09, 8'h22);
    rd(6'h12, 8'hff);
    wr(6'h0c, 8'h44);
    rd(6'h13, 8'h07);
    rd(6'h0a, 8'h11);
    wr(6'h29, 8'hff);
    core.pulse(2'd0, 16'h00ff);
    rd(6'h21, 8'hfe);
    rd(6'h22, 8'h01);
    core.pulse(2'd1, 16'hbeef);
    rd(6'h1f, 8'hbe);
    rd(6'h20, 8'hef);
    core.pulse(2'd2, 16'h2abc);
    rd(6'h16, 8'h2a);
    rd(6'h17, 8'hbc);
    resetn <= 1'b0;
    @(posedge ref_clk) resetn <= 1'b1;
    rd(6'h1a, 8'h00);
    end_sim;
  end
endmodule
